// ---- verilog/cc_params.svh ----
// Selector codes, field positions, reset values and timing counts for the clock controller
// Assumes a 40 MHz reference clock
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH
`define CC_CLK_MHZ 40
`define CC_STB_TIME_NS 100000
`define CC_STB_CYCLES ((`CC_STB_TIME_NS * `CC_CLK_MHZ) / 1000)
`define CC_STB_TERM 12'(`CC_STB_CYCLES - 1)
`define CC_SEL_HS_XTAL 3'h0
`define CC_SEL_LS_XTAL 3'h1
`define CC_SEL_PLL 3'h2
`define CC_SEL_LS_RC 3'h3
`define CC_SEL_RC48M 3'h4
`define CC_SEL_MED_RC 3'h5
`define CC_SEL_RC12M 3'h7
`define CC_SEL_RESET 3'h7
`define CC_STB_HS_XTAL 0
`define CC_STB_LS_XTAL 1
`define CC_STB_PLL 2
`define CC_STB_LS_RC 3
`define CC_STB_RC12M 4
`define CC_STB_MED_RC 5
`define CC_STB_RC48M 6
`define CC_STB_EXT_LS_XTAL 8
`define CC_STB_INT_32K 9
`endif

// ---- verilog/cc_pkg.sv ----
// Types shared by the clock controller
// Assumes cc_params.svh for numeric constants
package cc_pkg;
  typedef struct packed {
    logic high_speed_crystal;
    logic low_speed_crystal;
    logic pll;
    logic low_speed_rc_osc;
    logic rc12m_osc;
    logic medium_rc_osc;
    logic rc48m_osc;
  } cc_osc_s;
  typedef enum logic [3:0] {
    CC_SW_IDLE = 4'b0001,
    CC_SW_STOP = 4'b0010,
    CC_SW_SWAP = 4'b0100,
    CC_SW_RUN = 4'b1000
  } cc_sw_e;
endpackage

// ---- verilog/cc_clock_ctrl.sv ----
// Clock controller: source enables, stable flags, system clock switch, fail detectors,
// power-down gating, clock output divider and shared-register read gating.
// Assumes control bits come from registers on ref_clk_i; alive pins are asynchronous.
// What this block does
// RULE_01: Power-down entered on enable bit plus wait-for-interrupt, left on wake-up.
// RULE_02: Power-down stops high-speed crystal, 48 MHz, 12 MHz and medium oscillators.
// RULE_03: Software keeps old and new sources stable before any switch.
// RULE_04: Enabled source starts a stability counter; flag sets at terminal count.
// RULE_05: A source serves as a clock only while its stable flag is 1; the code checks the flag only when switching, not after reset or wake-up.
// RULE_06: Flags clear on disable; five flags also clear on power-down, recount after.
// RULE_07: Low-speed crystal flag follows either crystal enable or internal 32k enable.
// RULE_08: Stable flags sit at status bits 0..6, 8 and 9.
// RULE_09: System clock picked from seven sources by a 3-bit selector.
// RULE_10: Fail detectors force on the 12 MHz and low-speed RC oscillators.
// RULE_11: High-speed crystal stop switches system clock to 12 MHz RC.
// RULE_12: High-speed crystal stop sets fail flag 0, interrupt when enabled.
// RULE_13: Crystal stop clears its stable flag; software re-enables to recover.
// RULE_14: Low-speed crystal stop switches system clock to low-speed RC.
// RULE_15: Low-speed crystal stop sets fail flag 1, interrupt when enabled.
// RULE_16: Tick clock is CPU clock or one of five external tick sources.
// RULE_17: Power-down keeps low-speed sources, and medium RC when a timer needs it.
// RULE_18: Clock output uses 16 divide-by-2 stages, output is input over 2^(N+1).
// RULE_19: Enable starts the chain; disable runs until low, then holds low.
// RULE_20: Divide-by-one bit sends the source straight to the output pin.
// RULE_21: No clock on the output pin during power-down.
// RULE_22: With sharing on, non-secure reads allowed, non-secure writes refused.
// RULE_23: Fallback switching never produces a truncated system clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cc_params.svh"
module cc_clock_ctrl import cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic powerdown_enable_i,
  input wire logic wfi_i,
  input wire logic wakeup_i,
  input wire logic hs_crystal_enable_i,
  input wire logic ls_crystal_enable_i,
  input wire logic internal_32k_enable_i,
  input wire logic ls_rc_enable_i,
  input wire logic rc12m_enable_i,
  input wire logic medium_rc_enable_i,
  input wire logic rc48m_enable_i,
  input wire logic pll_power_down_i,
  input wire logic pll_src_rc12m_i,
  input wire logic medium_rc_keep_i,
  input wire logic hs_alive_i,
  input wire logic ls_alive_i,
  input wire logic hs_detect_enable_i,
  input wire logic ls_detect_enable_i,
  input wire logic hs_crystal_fail_irq_enable_i,
  input wire logic ls_crystal_fail_irq_enable_i,
  input wire logic hs_fail_clear_i,
  input wire logic ls_fail_clear_i,
  input wire logic [2:0] system_clock_select_i,
  input wire logic [2:0] tick_clock_select_i,
  input wire logic tick_external_i,
  input wire logic [3:0] output_divider_select_i,
  input wire logic clock_output_enable_i,
  input wire logic divide_by_one_enable_i,
  input wire logic clock_share_enable_i,
  input wire logic ns_read_i,
  input wire logic ns_write_i,
  output cc_osc_s osc_run_o,
  output logic [9:0] stable_o,
  output logic [2:0] sys_clk_sel_o,
  output logic sys_clk_gate_o,
  output logic [2:0] tick_clk_sel_o,
  output logic tick_external_o,
  output logic hs_crystal_fail_flag_o,
  output logic ls_crystal_fail_flag_o,
  output logic hs_fail_irq_o,
  output logic ls_fail_irq_o,
  output logic powerdown_o,
  output logic clock_output_pin_o,
  output logic ns_read_grant_o,
  output logic ns_write_error_o
);
  logic pd_ff, hs_s1_ff, hs_s2_ff, ls_s1_ff, ls_s2_ff;
  logic [9:0] stb_ff;
  logic [11:0] cnt_ff [10];
  logic [9:0] src_en, src_clr;
  logic hs_dead_ff, ls_dead_ff, hs_flag_ff, ls_flag_ff, hs_fail_evt, ls_fail_evt;
  logic hs_fb_ff, ls_fb_ff;
  logic [2:0] sel_ff, sel_in_ff, target;
  cc_sw_e sw_ff;
  logic [2:0] tick_sel_ff;
  logic tick_ext_ff;
  logic [15:0] div_ff;
  logic div_run_ff, div_out_ff, div1_ff;
  logic nsr_ff, nsw_ff;

  function automatic logic src_stable(input logic [2:0] s, input logic [9:0] f);
    case (s)
      `CC_SEL_HS_XTAL: src_stable = f[`CC_STB_HS_XTAL];
      `CC_SEL_LS_XTAL: src_stable = f[`CC_STB_LS_XTAL];
      `CC_SEL_PLL: src_stable = f[`CC_STB_PLL];
      `CC_SEL_LS_RC: src_stable = f[`CC_STB_LS_RC];
      `CC_SEL_RC48M: src_stable = f[`CC_STB_RC48M];
      `CC_SEL_MED_RC: src_stable = f[`CC_STB_MED_RC];
      default: src_stable = f[`CC_STB_RC12M];
    endcase
  endfunction

  // RULE_01 power-down entry and exit
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_ff <= 1'b0;
    end else if (pd_ff && wakeup_i) begin
      pd_ff <= 1'b0;
    end else if (powerdown_enable_i && wfi_i) begin
      pd_ff <= 1'b1;
    end
  end
  assign powerdown_o = pd_ff;

  // Crystal alive synchronisers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_s1_ff <= 1'b0;
      hs_s2_ff <= 1'b0;
      ls_s1_ff <= 1'b0;
      ls_s2_ff <= 1'b0;
    end else begin
      hs_s1_ff <= hs_alive_i;
      hs_s2_ff <= hs_s1_ff;
      ls_s1_ff <= ls_alive_i;
      ls_s2_ff <= ls_s1_ff;
    end
  end

  // RULE_02 RULE_10 RULE_17 effective oscillator enables
  always_comb begin
    osc_run_o.high_speed_crystal = hs_crystal_enable_i && !pd_ff;
    osc_run_o.low_speed_crystal = ls_crystal_enable_i || internal_32k_enable_i;
    osc_run_o.pll = !pll_power_down_i && !pd_ff;
    osc_run_o.low_speed_rc_osc = ls_rc_enable_i || ls_detect_enable_i;
    osc_run_o.rc12m_osc = (rc12m_enable_i || hs_detect_enable_i) && !pd_ff;
    osc_run_o.medium_rc_osc = medium_rc_enable_i && (!pd_ff || medium_rc_keep_i);
    osc_run_o.rc48m_osc = rc48m_enable_i && !pd_ff;
  end

  // RULE_07 RULE_08 source enable per status bit
  always_comb begin
    src_en = {internal_32k_enable_i, ls_crystal_enable_i, 1'b0,
              osc_run_o.rc48m_osc, osc_run_o.medium_rc_osc, osc_run_o.rc12m_osc,
              osc_run_o.low_speed_rc_osc, osc_run_o.pll, osc_run_o.low_speed_crystal,
              osc_run_o.high_speed_crystal};
    src_clr = 10'h000;
    src_clr[`CC_STB_HS_XTAL] = hs_dead_ff;
    src_clr[`CC_STB_LS_XTAL] = ls_dead_ff;
    src_clr[`CC_STB_EXT_LS_XTAL] = ls_dead_ff;
  end

  // RULE_04 RULE_06 stability counters and flags
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stb_ff <= 10'h000;
      for (int k = 0; k < 10; k++) begin
        cnt_ff[k] <= 12'h000;
      end
    end else begin
      for (int k = 0; k < 10; k++) begin
        if (!src_en[k] || src_clr[k]) begin
          cnt_ff[k] <= 12'h000;
          stb_ff[k] <= 1'b0;
        end else if (cnt_ff[k] == `CC_STB_TERM) begin
          stb_ff[k] <= 1'b1;
        end else begin
          cnt_ff[k] <= cnt_ff[k] + 12'h001;
        end
      end
    end
  end
  assign stable_o = stb_ff;

  a_stb_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_04
    src_en[4] && !stb_ff[4] && cnt_ff[4] == `CC_STB_TERM |=> stb_ff[4])
    else $error("stable flag not set at terminal count");
  a_stb_pd_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_06
    pd_ff |=> !stb_ff[0] && !stb_ff[2] && !stb_ff[4] && !stb_ff[6])
    else $error("stable flag survives power-down");
  a_pd_osc_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_02
    pd_ff |-> !osc_run_o.high_speed_crystal && !osc_run_o.rc12m_osc
              && !osc_run_o.rc48m_osc)
    else $error("oscillator left running in power-down");

  // RULE_11 RULE_12 RULE_13 RULE_14 RULE_15 fail detectors
  assign hs_fail_evt = hs_detect_enable_i && stb_ff[`CC_STB_HS_XTAL] && !hs_s2_ff;
  assign ls_fail_evt = ls_detect_enable_i && stb_ff[`CC_STB_LS_XTAL] && !ls_s2_ff;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_dead_ff <= 1'b0;
      ls_dead_ff <= 1'b0;
    end else begin
      hs_dead_ff <= hs_crystal_enable_i && (hs_dead_ff || hs_fail_evt);
      ls_dead_ff <= osc_run_o.low_speed_crystal && (ls_dead_ff || ls_fail_evt);
    end
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_flag_ff <= 1'b0;
      ls_flag_ff <= 1'b0;
    end else begin
      hs_flag_ff <= hs_fail_evt || (hs_flag_ff && !hs_fail_clear_i);
      ls_flag_ff <= ls_fail_evt || (ls_flag_ff && !ls_fail_clear_i);
    end
  end
  assign hs_crystal_fail_flag_o = hs_flag_ff;
  assign ls_crystal_fail_flag_o = ls_flag_ff;
  assign hs_fail_irq_o = hs_flag_ff && hs_crystal_fail_irq_enable_i;
  assign ls_fail_irq_o = ls_flag_ff && ls_crystal_fail_irq_enable_i;

  a_hs_fail_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_12
    hs_fail_evt |=> hs_crystal_fail_flag_o ##1 !stb_ff[`CC_STB_HS_XTAL])
    else $error("high-speed fail flag or stable clear missing");
  a_ls_fail_irq: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_15
    ls_fail_evt |=> ls_crystal_fail_flag_o && ls_fail_irq_o == ls_crystal_fail_irq_enable_i)
    else $error("low-speed fail interrupt missing");

  // Fallback request held until software writes a new selection
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_in_ff <= `CC_SEL_RESET;
      hs_fb_ff <= 1'b0;
      ls_fb_ff <= 1'b0;
    end else begin
      sel_in_ff <= system_clock_select_i;
      hs_fb_ff <= (hs_fail_evt && (sel_ff == `CC_SEL_HS_XTAL
                   || (sel_ff == `CC_SEL_PLL && !pll_src_rc12m_i)))
                  || (hs_fb_ff && sel_in_ff == system_clock_select_i);
      ls_fb_ff <= (ls_fail_evt && sel_ff == `CC_SEL_LS_XTAL)
                  || (ls_fb_ff && sel_in_ff == system_clock_select_i);
    end
  end
  always_comb begin
    if (hs_fb_ff) begin
      target = `CC_SEL_RC12M;
    end else if (ls_fb_ff) begin
      target = `CC_SEL_LS_RC;
    end else begin
      target = system_clock_select_i;
    end
  end

  // RULE_05 RULE_09 RULE_23 gate-stop-swap-restart clock switch
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_ff <= CC_SW_IDLE;
      sel_ff <= `CC_SEL_RESET;
    end else begin
      case (sw_ff)
        CC_SW_IDLE: begin
          if (target != sel_ff && src_stable(target, stb_ff)) begin
            sw_ff <= CC_SW_STOP;
          end
        end
        CC_SW_STOP: begin
          sw_ff <= CC_SW_SWAP;
        end
        CC_SW_SWAP: begin
          sel_ff <= target;
          sw_ff <= CC_SW_RUN;
        end
        CC_SW_RUN: begin
          sw_ff <= CC_SW_IDLE;
        end
        default: begin
          sw_ff <= CC_SW_IDLE;
        end
      endcase
    end
  end
  assign sys_clk_sel_o = sel_ff;
  assign sys_clk_gate_o = (sw_ff == CC_SW_IDLE) && !pd_ff;

  a_sel_gated: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_23
    $changed(sel_ff) |-> !sys_clk_gate_o && $past(sw_ff == CC_SW_SWAP))
    else $error("selector changed while clock ungated");
  a_sel_stable: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_05
    sw_ff == CC_SW_IDLE && target != sel_ff && !src_stable(target, stb_ff)
    |=> sw_ff == CC_SW_IDLE)
    else $error("switched to an unstable source");
  a_hs_fallback: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_11
    hs_fail_evt && sel_ff == `CC_SEL_HS_XTAL && sw_ff == CC_SW_IDLE && stb_ff[`CC_STB_RC12M]
    && !pd_ff |-> ##[4:5] sel_ff == `CC_SEL_RC12M)
    else $error("no fallback to 12 MHz RC");

  // RULE_16 tick clock selection
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_sel_ff <= 3'h0;
      tick_ext_ff <= 1'b0;
    end else begin
      tick_sel_ff <= tick_clock_select_i;
      tick_ext_ff <= tick_external_i;
    end
  end
  assign tick_clk_sel_o = tick_sel_ff;
  assign tick_external_o = tick_ext_ff;

  // RULE_18 RULE_19 RULE_21 divider chain
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= 16'h0000;
      div_run_ff <= 1'b0;
      div_out_ff <= 1'b0;
      div1_ff <= 1'b0;
    end else begin
      div1_ff <= divide_by_one_enable_i && clock_output_enable_i && !pd_ff;
      if (clock_output_enable_i) begin
        div_run_ff <= 1'b1;
      end else if (!div_ff[output_divider_select_i]) begin
        div_run_ff <= 1'b0;
      end
      if (div_run_ff && (clock_output_enable_i || div_ff[output_divider_select_i])) begin
        div_ff <= div_ff + 16'h0001;
        div_out_ff <= div_ff[output_divider_select_i] && !pd_ff;
      end else begin
        div_ff <= 16'h0000;
        div_out_ff <= 1'b0;
      end
    end
  end
  // RULE_20 divider bypass
  assign clock_output_pin_o = div1_ff ? ref_clk_i : div_out_ff;

  a_clock_output_pin_pd: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_21
    pd_ff && $past(pd_ff) |-> !div_out_ff && !div1_ff)
    else $error("clock output active in power-down");
  a_clock_output_pin_stop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_19
    !clock_output_enable_i && !div_ff[output_divider_select_i] |=> !div_run_ff && !div_out_ff)
    else $error("divided clock not held low");

  // RULE_22 non-secure shared read gating
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nsr_ff <= 1'b0;
      nsw_ff <= 1'b0;
    end else begin
      nsr_ff <= ns_read_i && clock_share_enable_i;
      nsw_ff <= ns_write_i;
    end
  end
  assign ns_read_grant_o = nsr_ff;
  assign ns_write_error_o = nsw_ff;

  a_ns_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_22
    ns_read_i && !clock_share_enable_i |=> !ns_read_grant_o)
    else $error("non-secure read granted without sharing");
  a_pd_entry: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RULE_01
    !pd_ff && !(powerdown_enable_i && wfi_i) |=> !pd_ff)
    else $error("power-down without enable and wait");
endmodule // cc_clock_ctrl
`default_nettype wire

// ---- tb/cc_clock_ctrl_test.sv ----
// Self-checking bench for the clock controller, every input driven at the falling edge
// Assumes the 4000-cycle stable count and the 40 MHz reference of the design
`timescale 1ns/1ps
`default_nettype none
module cc_clock_ctrl_test import cc_pkg::*;;
  logic ref_clk_i, reset_n_i, powerdown_enable_i, wfi_i, wakeup_i, hs_crystal_enable_i;
  logic ls_crystal_enable_i, internal_32k_enable_i, ls_rc_enable_i, rc12m_enable_i;
  logic medium_rc_enable_i, rc48m_enable_i, pll_power_down_i, pll_src_rc12m_i;
  logic medium_rc_keep_i, hs_alive_i, ls_alive_i, hs_detect_enable_i, ls_detect_enable_i;
  logic hs_crystal_fail_irq_enable_i, ls_crystal_fail_irq_enable_i, hs_fail_clear_i;
  logic ls_fail_clear_i, tick_external_i, clock_output_enable_i, divide_by_one_enable_i;
  logic clock_share_enable_i, ns_read_i, ns_write_i;
  logic [2:0] system_clock_select_i, tick_clock_select_i;
  logic [3:0] output_divider_select_i;
  cc_osc_s osc_run_o;
  logic [9:0] stable_o;
  logic [2:0] sys_clk_sel_o, tick_clk_sel_o;
  logic sys_clk_gate_o, tick_external_o, hs_crystal_fail_flag_o, ls_crystal_fail_flag_o;
  logic hs_fail_irq_o, ls_fail_irq_o, powerdown_o, clock_output_pin_o, ns_read_grant_o;
  logic ns_write_error_o;
  logic [5:0] obs;
  int failures, checked;
  int nq[$] = {0, 1, 2, 3};

  assign obs = {clock_output_pin_o, ls_crystal_fail_flag_o, hs_crystal_fail_flag_o, sys_clk_sel_o};

  cc_clock_ctrl DUT (.ref_clk_i, .reset_n_i, .powerdown_enable_i, .wfi_i, .wakeup_i,
    .hs_crystal_enable_i, .ls_crystal_enable_i, .internal_32k_enable_i, .ls_rc_enable_i,
    .rc12m_enable_i, .medium_rc_enable_i, .rc48m_enable_i, .pll_power_down_i, .pll_src_rc12m_i,
    .medium_rc_keep_i, .hs_alive_i, .ls_alive_i, .hs_detect_enable_i, .ls_detect_enable_i,
    .hs_crystal_fail_irq_enable_i, .ls_crystal_fail_irq_enable_i, .hs_fail_clear_i,
    .ls_fail_clear_i, .system_clock_select_i, .tick_clock_select_i, .tick_external_i,
    .output_divider_select_i, .clock_output_enable_i, .divide_by_one_enable_i,
    .clock_share_enable_i, .ns_read_i, .ns_write_i, .osc_run_o, .stable_o, .sys_clk_sel_o,
    .sys_clk_gate_o, .tick_clk_sel_o, .tick_external_o, .hs_crystal_fail_flag_o,
    .ls_crystal_fail_flag_o, .hs_fail_irq_o, .ls_fail_irq_o, .powerdown_o, .clock_output_pin_o,
    .ns_read_grant_o, .ns_write_error_o);

  always #12.5 ref_clk_i = ~ref_clk_i;

  task wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Bounded wait on a masked view of the outputs
  task waitf(input string nm, input logic [5:0] m, input logic [5:0] v, input int b);
    int i;
    for (i = 0; i < b && (obs & m) !== v; i++) cyc(1);
    chk(nm, 16'(v), 16'(obs & m));
    if ((obs & m) !== v) wrap_up();
  endtask

  task pulse_wfi;
    wfi_i = 1;
    cyc(1);
    wfi_i = 0;
    cyc(2);
  endtask

  initial begin
    #2000000;
    failures++;
    wrap_up();
  end

  initial begin
    int k, n, p, c;
    logic [2:0] s;
    {ref_clk_i, reset_n_i, powerdown_enable_i, wfi_i, wakeup_i, hs_crystal_enable_i,
     ls_crystal_enable_i, internal_32k_enable_i, ls_rc_enable_i, rc12m_enable_i,
     medium_rc_enable_i, rc48m_enable_i, medium_rc_keep_i, hs_detect_enable_i,
     ls_detect_enable_i, hs_crystal_fail_irq_enable_i, ls_crystal_fail_irq_enable_i,
     hs_fail_clear_i, ls_fail_clear_i, tick_external_i, clock_output_enable_i,
     divide_by_one_enable_i, ns_read_i, ns_write_i} = '0;
    {pll_power_down_i, pll_src_rc12m_i, hs_alive_i, ls_alive_i, clock_share_enable_i} = '1;
    system_clock_select_i = 3'h7;
    tick_clock_select_i = 3'h0;
    output_divider_select_i = 4'h0;
    k = $urandom(32'h7a66);
    cyc(2);
    reset_n_i = 1;
    chk("sys_clk_sel_o", 16'h7, 16'(sys_clk_sel_o)); // Reset selector
    chk("stable_o", 16'h0, 16'(stable_o)); // Nothing stable
    {hs_crystal_enable_i, ls_crystal_enable_i, internal_32k_enable_i, ls_rc_enable_i} = '1;
    {rc12m_enable_i, medium_rc_enable_i, rc48m_enable_i} = '1;
    pll_power_down_i = 0;
    cyc(3999);
    chk("stable_o", 16'h0, 16'(stable_o)); // Not before terminal count
    cyc(1);
    chk("stable_o", 16'h37f, 16'(stable_o)); // Flags at their bits
    ls_crystal_enable_i = 0;
    medium_rc_enable_i = 0;
    cyc(2);
    chk("stable_o", 16'h25f, 16'(stable_o)); // Disable clears
    medium_rc_enable_i = 1;
    pulse_wfi();
    chk("powerdown_o", 16'h0, 16'(powerdown_o)); // No entry without enable
    powerdown_enable_i = 1;
    pulse_wfi();
    chk("powerdown_o", 16'h1, 16'(powerdown_o)); // Entry
    chk("osc_run_o", 16'h28, 16'(osc_run_o)); // Fast sources stop
    chk("stable_o", 16'h20a, 16'(stable_o)); // Flags cleared
    chk("sys_clk_gate_o", 16'h0, 16'(sys_clk_gate_o)); // No system clock
    medium_rc_keep_i = 1;
    cyc(1);
    chk("osc_run_o", 16'h2a, 16'(osc_run_o)); // Medium kept for timers
    wakeup_i = 1;
    cyc(1);
    wakeup_i = 0;
    medium_rc_keep_i = 0;
    ls_crystal_enable_i = 1;
    cyc(1);
    chk("powerdown_o", 16'h0, 16'(powerdown_o)); // Wake-up
    cyc(4002);
    chk("stable_o", 16'h37f, 16'(stable_o)); // Recount after wake
    for (k = 0; k < 7; k++) begin
      s = (k == 6) ? 3'h7 : 3'(k);
      system_clock_select_i = s;
      waitf("sys_clk_sel_o", 6'h07, {3'h0, s}, 20); // Each stable source
    end
    rc48m_enable_i = 0;
    cyc(2);
    system_clock_select_i = 3'h4;
    cyc(12);
    chk("sys_clk_sel_o", 16'h7, 16'(sys_clk_sel_o)); // Unstable target refused
    system_clock_select_i = 3'h0;
    waitf("sys_clk_sel_o", 6'h07, 6'h00, 20); // Switch to crystal
    {hs_detect_enable_i, hs_crystal_fail_irq_enable_i} = '1;
    hs_alive_i = 0;
    waitf("hs fail flag", 6'h08, 6'h08, 10); // Stop sets flag
    chk("hs_fail_irq_o", 16'h1, 16'(hs_fail_irq_o)); // Interrupt
    waitf("sys_clk_sel_o", 6'h07, 6'h07, 10); // Fallback to 12 MHz RC
    cyc(2);
    chk("stable_o bit 0", 16'h0, 16'(stable_o[0])); // Stable cleared
    hs_fail_clear_i = 1;
    cyc(1);
    hs_fail_clear_i = 0;
    system_clock_select_i = 3'h7;
    hs_alive_i = 1;
    hs_crystal_enable_i = 0;
    cyc(1);
    chk("hs fail flag", 16'h0, 16'(hs_crystal_fail_flag_o)); // Flag cleared
    hs_crystal_enable_i = 1;
    cyc(4002);
    chk("stable_o bit 0", 16'h1, 16'(stable_o[0])); // Recovered crystal
    pll_src_rc12m_i = 0;
    system_clock_select_i = 3'h2;
    waitf("sys_clk_sel_o", 6'h07, 6'h02, 20); // Crystal-fed PLL
    hs_alive_i = 0;
    waitf("sys_clk_sel_o", 6'h07, 6'h07, 14); // PLL fallback to 12 MHz RC
    hs_alive_i = 1;
    system_clock_select_i = 3'h1;
    waitf("sys_clk_sel_o", 6'h07, 6'h01, 20); // Switch to low crystal
    ls_detect_enable_i = 1;
    ls_alive_i = 0;
    waitf("ls fail flag", 6'h10, 6'h10, 10); // Stop sets flag
    chk("ls_fail_irq_o", 16'h0, 16'(ls_fail_irq_o)); // Masked
    waitf("sys_clk_sel_o", 6'h07, 6'h03, 10); // Fallback to low RC
    ls_crystal_fail_irq_enable_i = 1;
    cyc(2);
    chk("ls_fail_irq_o", 16'h1, 16'(ls_fail_irq_o)); // Unmasked
    chk("stable_o bits 8 1", 16'h0, 16'({stable_o[8], stable_o[1]})); // Cleared
    {ls_fail_clear_i, ls_alive_i} = '1;
    system_clock_select_i = 3'h3;
    {rc12m_enable_i, ls_rc_enable_i} = '0;
    cyc(1);
    ls_fail_clear_i = 0;
    chk("forced rc", 16'h3, 16'({osc_run_o.rc12m_osc, osc_run_o.low_speed_rc_osc}));
    {hs_detect_enable_i, ls_detect_enable_i} = '0;
    cyc(1);
    chk("forced rc", 16'h0, 16'({osc_run_o.rc12m_osc, osc_run_o.low_speed_rc_osc}));
    repeat (3) begin
      tick_clock_select_i = 3'($urandom % 5);
      tick_external_i = 1'($urandom);
      cyc(2);
      chk("tick select", 16'({tick_external_i, tick_clock_select_i}),
          16'({tick_external_o, tick_clk_sel_o})); // Tick source
    end
    ns_read_i = 1;
    cyc(1);
    ns_read_i = 0;
    chk("ns_read_grant_o", 16'h1, 16'(ns_read_grant_o)); // Shared read
    clock_share_enable_i = 0;
    {ns_read_i, ns_write_i} = '1;
    cyc(1);
    {ns_read_i, ns_write_i} = '0;
    chk("share", 16'h1, 16'({ns_read_grant_o, ns_write_error_o})); // Refused
    nq.push_back(int'($urandom % 6));
    foreach (nq[j]) begin
      n = nq[j];
      p = 1 << (n + 1);
      output_divider_select_i = 4'(n);
      clock_output_enable_i = 1;
      waitf("clock_output_pin_o", 6'h20, 6'h20, p + 4); // Chain runs
      for (c = 0; obs[5] === 1'b1 && c < 200; c++) cyc(1);
      chk("high time", 16'(p / 2), 16'(c)); // Divide ratio
      for (c = 0; obs[5] === 1'b0 && c < 200; c++) cyc(1);
      chk("low time", 16'(p / 2), 16'(c)); // Divide ratio
      clock_output_enable_i = 0;
      waitf("clock_output_pin_o", 6'h20, 6'h00, p + 2); // Runs to low
      cyc(2 * p);
      chk("clock_output_pin_o", 16'h0, 16'(clock_output_pin_o)); // Held low
    end
    {clock_output_enable_i, divide_by_one_enable_i} = '1;
    cyc(3);
    @(posedge ref_clk_i);
    #1;
    chk("bypass high", 16'h1, 16'(clock_output_pin_o)); // Straight out
    @(negedge ref_clk_i);
    #1;
    chk("bypass low", 16'h0, 16'(clock_output_pin_o)); // Straight out
    cyc(1);
    pulse_wfi();
    repeat (8) begin
      @(posedge ref_clk_i);
      #1;
      chk("clock_output_pin_o", 16'h0, 16'(clock_output_pin_o)); // Silent when down
    end
    cyc(1);
    wrap_up();
  end
endmodule // cc_clock_ctrl_test
`default_nettype wire
